// ===== include/adc_ctl_pkg.sv
/*
 * Shared constants of the converter control block: register addresses,
 * field positions, reset values and the conversion timing table.
 * Assumes byte addresses on the internal peripheral bus and that the
 * converter runs on the peripheral clock.
 */
package adc_ctl_pkg;

	// ************************************************************
	// Register addresses
	// ************************************************************
	localparam logic [15:0] ADDR_RES_LO = 16'hff18;
	localparam logic [15:0] ADDR_RES_HI = 16'hff19;
	localparam logic [15:0] ADDR_RES_SHORT = 16'hff1a;
	localparam logic [15:0] ADDR_MODE = 16'hff80;
	localparam logic [15:0] ADDR_CHAN = 16'hff81;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_POWER_BIT = 0;
	localparam int MODE_SEL_LSB = 3;
	localparam logic [7:0] MODE_WMASK = 8'hb9;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [1:0] CHAN_RESET = 2'h0;
	localparam int RES_W = 10;
	localparam int SHORT_LSB = 2;

	// ************************************************************
	// Timing table, in peripheral clock periods, indexed by selector
	// ************************************************************
	localparam logic [7:0] SAMPLE_LEN [8] = '{
		8'h0c, 8'h18, 8'h30, 8'h58, 8'h18, 8'h30, 8'h60, 8'hb0
	};
	localparam logic [7:0] TOTAL_LEN [8] = '{
		8'h24, 8'h30, 8'h48, 8'h70, 8'h48, 8'h60, 8'h90, 8'he0
	};
	localparam logic [7:0] BIT_SLOTS = 8'h0a;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_COMPARE = 2'b10
	} seq_state_t;

endpackage

// ===== rtl/conv_timer.sv
/*
 * Conversion timer: counts one conversion and marks the end of sampling,
 * each bit decision slot and the end of the conversion.
 * Assumes start and halt come from the sequencer and are never both high.
 */
module conv_timer (
	input logic clk,
	input logic rstn,
	input logic start,
	input logic halt,
	input logic [2:0] time_sel,
	output logic sample_end,
	output logic bit_step,
	output logic conv_end
);

	logic [7:0] cnt_q;
	logic [7:0] sub_q;
	logic active_q;
	logic [7:0] s_len;
	logic [7:0] t_len;
	logic [7:0] step_len;
	logic cmp_phase;

	// The decision slots end at least one cycle before the total, so that the last
	// decided bit is already in the register when the result is taken.
	assign s_len = adc_ctl_pkg::SAMPLE_LEN[time_sel]; // [R3]
	assign t_len = adc_ctl_pkg::TOTAL_LEN[time_sel]; // [R4]
	assign step_len = (t_len - s_len - 8'h01) / adc_ctl_pkg::BIT_SLOTS;
	assign cmp_phase = active_q && (cnt_q >= s_len);
	assign sample_end = active_q && (cnt_q == s_len - 8'h01);
	assign bit_step = cmp_phase && (sub_q == step_len - 8'h01); // [R27]
	assign conv_end = active_q && (cnt_q == t_len - 8'h01); // [R4]

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 8'h00;
			active_q <= 1'b0;
		end else if (start) begin
			cnt_q <= 8'h00;
			active_q <= 1'b1;
		end else if (halt) begin
			active_q <= 1'b0;
		end else if (active_q) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sub_q <= 8'h00;
		end else if (start || sample_end || bit_step) begin
			sub_q <= 8'h00;
		end else if (cmp_phase) begin
			sub_q <= sub_q + 8'h01;
		end
	end

endmodule // conv_timer

// ===== rtl/approx_reg.sv
/*
 * Successive approximation register: trial bit from the top down, kept or
 * dropped on the comparator decision.
 * Assumes the decision input answers the trial code in the same cycle.
 */
module approx_reg #(
	parameter int W = 10
) (
	input logic clk,
	input logic rstn,
	input logic load,
	input logic step,
	input logic decision,
	output logic [W-1:0] value
);

	logic [W-1:0] mask_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			value <= '0;
			mask_q <= '0;
		end else if (load) begin
			value <= W'(1) << (W - 1);
			mask_q <= W'(1) << (W - 1);
		end else if (step && (mask_q != '0)) begin
			// A low decision drops the trial bit; the next one is tried.
			value <= (decision ? value : (value & ~mask_q)) | (mask_q >> 1); // [R27]
			mask_q <= mask_q >> 1;
		end
	end

endmodule // approx_reg

// ===== rtl/sar_adc_control_regs.sv
/*
 * Control and result registers of a four-input, 10-bit successive
 * approximation converter, with its conversion sequencer.
 * Assumes a byte-wide peripheral bus with single-bit writes and 16-bit
 * reads, and an analog front end that answers the trial code at once.
 */
// Functional notes
// R1 - Mode bit 7 starts conversion when set and halts it when cleared.
// R2 - Mode bit 0 powers the comparator on when one.
// R3 - Mode bits 5:3 pick sampling and total lengths from the table.
// R4 - Total length covers sampling plus comparison up to result delivery.
// R5 - Setting run starts conversion even with the comparator off.
// R6 - Software waits 1 us after comparator power-on, or drops first result.
// R7 - Stop, comparator-only wait, or converting whatever the power bit says.
// R8 - Software picks a sampling length meeting the supply minimum.
// R9 - Software keeps total time above the minimum and below 100 us.
// R10 - Software waits two machine cycles after other mode changes before run.
// R11 - Software clears run before changing the time selector.
// R12 - Mode bits 6, 2 and 1 are written zero and read zero.
// R13 - Channel bits 1:0 select analog input 0 to 3.
// R14 - Software writes channel bits 7 to 2 as zero.
// R15 - Full result is 16 bits, upper six zero, reloaded every conversion.
// R16 - Upper byte holds result bits 9:8, lower byte bits 7:0.
// R17 - Software reads the full result in one 16-bit access.
// R18 - Mode or channel writes may spoil the result; read before writing.
// R19 - Short result shows the upper eight result bits, byte read.
// R20 - Reset leaves both result registers undefined.
// R21 - Mode and channel take bit and byte writes, reset to zero.
// R22 - Software adds margin for clock tolerance, up to five percent.
// R23 - Conversions repeat back to back until run is cleared.
// R24 - Mode or channel write aborts a conversion and restarts if running.
// R25 - Clearing run stops conversion at once; partial result undefined.
// R26 - Each completion loads both results and pulses the done request.
// R27 - Bits resolve from 9 down to 0 within the comparison budget.
// R28 - Result reads have no side effects; writes to them are ignored.
module sar_adc_control_regs (
	input logic clk,
	input logic rstn,
	input logic [15:0] bus_addr,
	input logic bus_wr,
	input logic bus_rd,
	input logic bus_bit_op,
	input logic [2:0] bus_bit_sel,
	input logic [7:0] bus_wdata,
	input logic bus_wide,
	output logic [15:0] bus_rdata,
	output logic bus_rvalid,
	input logic comp_decision,
	output logic comparator_on,
	output logic sample_hold,
	output logic [1:0] channel_sel,
	output logic [9:0] dac_code,
	output logic conversion_done_irq
);

	// ************************************************************
	// Register writes
	// ************************************************************
	logic [7:0] mode_q;
	logic [7:0] mode_new;
	logic [7:0] chan_new;
	logic wr_mode;
	logic wr_chan;
	logic kick_q;
	logic run;
	logic power;
	logic [2:0] time_sel;

	assign wr_mode = bus_wr && (bus_addr == adc_ctl_pkg::ADDR_MODE);
	assign wr_chan = bus_wr && (bus_addr == adc_ctl_pkg::ADDR_CHAN);
	assign run = mode_q[adc_ctl_pkg::MODE_RUN_BIT];
	assign power = mode_q[adc_ctl_pkg::MODE_POWER_BIT];
	assign time_sel = mode_q[adc_ctl_pkg::MODE_SEL_LSB +: 3];

	always_comb begin
		mode_new = mode_q;
		chan_new = {6'h00, channel_sel};
		if (bus_bit_op) begin
			mode_new[bus_bit_sel] = bus_wdata[0]; // [R21]
			chan_new[bus_bit_sel] = bus_wdata[0];
		end else begin
			mode_new = bus_wdata;
			chan_new = bus_wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= adc_ctl_pkg::MODE_RESET; // [R21]
		end else if (wr_mode) begin
			mode_q <= mode_new & adc_ctl_pkg::MODE_WMASK; // [R12] [R1]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			channel_sel <= adc_ctl_pkg::CHAN_RESET; // [R21]
		end else if (wr_chan) begin
			channel_sel <= chan_new[1:0]; // [R13]
		end
	end

	// Any write to either control register restarts the sequencer while run is set, so a
	// result already in flight is thrown away rather than half-updated.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			kick_q <= 1'b0;
		end else begin
			kick_q <= wr_mode || wr_chan; // [R24] [R18]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			comparator_on <= 1'b0;
		end else begin
			comparator_on <= run || power; // [R2] [R7]
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	adc_ctl_pkg::seq_state_t seq_st_q;
	adc_ctl_pkg::seq_state_t seq_st_d;
	logic sample_end;
	logic bit_step;
	logic conv_end;
	logic conv_ok;
	logic launch;

	assign conv_ok = (seq_st_q == adc_ctl_pkg::ST_COMPARE) && conv_end &&
		run && !kick_q; // [R26]
	assign launch = run && (kick_q || conv_ok); // [R23] [R24] [R5]

	always_comb begin
		seq_st_d = seq_st_q;
		if (!run) begin
			seq_st_d = adc_ctl_pkg::ST_IDLE; // [R25] [R7]
		end else if (launch) begin
			seq_st_d = adc_ctl_pkg::ST_SAMPLE;
		end else begin
			unique case (seq_st_q)
				adc_ctl_pkg::ST_IDLE: begin
					seq_st_d = adc_ctl_pkg::ST_IDLE;
				end
				adc_ctl_pkg::ST_SAMPLE: begin
					if (sample_end) begin
						seq_st_d = adc_ctl_pkg::ST_COMPARE; // [R3]
					end
				end
				adc_ctl_pkg::ST_COMPARE: begin
					seq_st_d = adc_ctl_pkg::ST_COMPARE;
				end
				default: begin
					seq_st_d = adc_ctl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seq_st_q <= adc_ctl_pkg::ST_IDLE;
			sample_hold <= 1'b0;
		end else begin
			seq_st_q <= seq_st_d;
			sample_hold <= (seq_st_d == adc_ctl_pkg::ST_SAMPLE);
		end
	end

	conv_timer u_timer (
		.clk(clk),
		.rstn(rstn),
		.start(launch),
		.halt(seq_st_d == adc_ctl_pkg::ST_IDLE),
		.time_sel(time_sel),
		.sample_end(sample_end),
		.bit_step(bit_step),
		.conv_end(conv_end)
	);

	approx_reg #(
		.W(adc_ctl_pkg::RES_W)
	) u_approx (
		.clk(clk),
		.rstn(rstn),
		.load((seq_st_q == adc_ctl_pkg::ST_SAMPLE) && (seq_st_d ==
			adc_ctl_pkg::ST_COMPARE)),
		.step((seq_st_q == adc_ctl_pkg::ST_COMPARE) && bit_step), // [R27]
		.decision(comp_decision),
		.value(dac_code)
	);

	// ************************************************************
	// Results and read path
	// ************************************************************
	logic [9:0] res_q;
	logic [7:0] short_res;

	assign short_res = res_q[adc_ctl_pkg::SHORT_LSB +: 8];

	// Left without reset on purpose: the value is meaningless until the
	// first conversion ends, and software must not rely on it before then.
	always_ff @(posedge clk) begin
		if (conv_ok) begin
			res_q <= dac_code; // [R15] [R20] [R26]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			conversion_done_irq <= 1'b0;
		end else begin
			conversion_done_irq <= conv_ok; // [R26]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_rdata <= 16'h0000;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= bus_rd;
			if (bus_rd) begin
				unique case (bus_addr)
					adc_ctl_pkg::ADDR_RES_LO: begin
						bus_rdata <= bus_wide ? {6'h00, res_q} :
							{8'h00, res_q[7:0]}; // [R16] [R17] [R28]
					end
					adc_ctl_pkg::ADDR_RES_HI: begin
						bus_rdata <= {14'h0000, res_q[9:8]}; // [R16]
					end
					adc_ctl_pkg::ADDR_RES_SHORT: begin
						bus_rdata <= {8'h00, short_res}; // [R19]
					end
					adc_ctl_pkg::ADDR_MODE: begin
						bus_rdata <= {8'h00, mode_q};
					end
					adc_ctl_pkg::ADDR_CHAN: begin
						bus_rdata <= {14'h0000, channel_sel};
					end
					default: begin
						bus_rdata <= 16'h0000;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	logic [7:0] samp_q;
	logic [7:0] cyc_q;
	logic [7:0] cur_s;
	logic [7:0] cur_t;
	logic [1:0] wdata_lo;

	assign cur_s = adc_ctl_pkg::SAMPLE_LEN[time_sel];
	assign cur_t = adc_ctl_pkg::TOTAL_LEN[time_sel];
	assign wdata_lo = bus_wdata[1:0];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			samp_q <= 8'h00;
			cyc_q <= 8'h00;
		end else begin
			if (launch || seq_st_q != adc_ctl_pkg::ST_SAMPLE) begin
				samp_q <= 8'h00;
			end else begin
				samp_q <= samp_q + 8'h01;
			end
			if (launch || seq_st_q == adc_ctl_pkg::ST_IDLE) begin
				cyc_q <= 8'h00;
			end else begin
				cyc_q <= cyc_q + 8'h01;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_sample_exit;
		seq_st_q == adc_ctl_pkg::ST_SAMPLE ##1
			seq_st_q == adc_ctl_pkg::ST_COMPARE;
	endsequence

	sequence s_cold_launch;
		$rose(run) && !power;
	endsequence

	a_run_launch: assert property ($rose(run) |=> // [R1]
		seq_st_q == adc_ctl_pkg::ST_SAMPLE) else $error("run did not start");
	a_stop_idle: assert property ($fell(run) |=> // [R25]
		seq_st_q == adc_ctl_pkg::ST_IDLE && !sample_hold)
		else $error("clear of run did not stop");
	a_comp_off: assert property ((!run && !power)[*2] |-> // [R2]
		!comparator_on) else $error("comparator on while stopped");
	a_idle_mode: assert property (!run[*2] |-> // [R7]
		seq_st_q == adc_ctl_pkg::ST_IDLE) else $error("active without run");
	a_cold_start: assert property (s_cold_launch |=> // [R5]
		sample_hold) else $error("no start with comparator off");
	a_sample_len: assert property (s_sample_exit |-> // [R3]
		$past(samp_q) == cur_s - 8'h01) else $error("wrong sampling length");
	a_total_len: assert property (conversion_done_irq |-> // [R4]
		$past(cyc_q) == cur_t - 8'h01) else $error("wrong conversion length");
	a_result_load: assert property (conversion_done_irq |-> // [R15]
		res_q == $past(dac_code)) else $error("result not loaded");
	a_back_to_back: assert property (conversion_done_irq |-> // [R23]
		seq_st_q == adc_ctl_pkg::ST_SAMPLE) else $error("no back to back");
	a_abort_restart: assert property (kick_q && run |=> // [R24]
		seq_st_q == adc_ctl_pkg::ST_SAMPLE && !conversion_done_irq)
		else $error("write did not restart");
	a_irq_pulse: assert property (conversion_done_irq |=> // [R26]
		!conversion_done_irq) else $error("done request too long");
	a_short_read: assert property (bus_rd && // [R19]
		bus_addr == adc_ctl_pkg::ADDR_RES_SHORT |=>
		bus_rvalid && bus_rdata[7:0] == $past(short_res))
		else $error("short result read wrong");
	a_chan_write: assert property (wr_chan && !bus_bit_op |=> // [R13]
		channel_sel == $past(wdata_lo)) else $error("channel not taken");

endmodule // sar_adc_control_regs

// ===== tb/afe_model.sv
/*
 * Analog front end model: sample and hold, comparator with settling time.
 * Assumes levels packs one ten-bit input level per channel, input 0 lowest.
 */
module afe_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic comparator_on,
	input wire logic sample_hold,
	input wire logic [1:0] channel_sel,
	input wire logic [9:0] dac_code,
	input wire logic [39:0] levels,
	output logic comp_decision
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [9:0] held_q;
	logic [4:0] settle_q;
	logic flip_q;

	// ********************************
	// Sampling and settling
	// ********************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			held_q <= 10'h000;
			settle_q <= 5'h00;
			flip_q <= 1'b0;
		end else begin
			flip_q <= ~flip_q;
			if (!comparator_on) begin
				settle_q <= 5'h00;
			end else if (settle_q != 5'h19) begin
				settle_q <= settle_q + 5'h01;
			end
			if (sample_hold) begin
				held_q <= levels[channel_sel * 10 +: 10];
			end
		end
	end

	// An unsettled comparator is no help: its answer changes every cycle.
	assign comp_decision = (comparator_on && settle_q == 5'h19) ?
		(held_q >= dac_code) : flip_q;
endmodule // afe_model

// ===== tb/sar_adc_control_regs_tb.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the analog front end model answers the trial code at once.
 */
module sar_adc_control_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, rstn, bus_wr, bus_rd, bus_bit_op, bus_wide, bus_rvalid;
	logic comp_decision, comparator_on, sample_hold, conversion_done_irq;
	logic [15:0] bus_addr, bus_rdata;
	logic [2:0] bus_bit_sel;
	logic [7:0] bus_wdata;
	logic [1:0] channel_sel;
	logic [9:0] dac_code, lv;
	logic [7:0] md;
	localparam logic [39:0] LV = {10'h001, 10'h3ff, 10'h15a, 10'h2a5};
	logic [7:0] sample_tab [8] = '{8'h0c, 8'h18, 8'h30, 8'h58,
		8'h18, 8'h30, 8'h60, 8'hb0};
	logic [7:0] total_tab [8] = '{8'h24, 8'h30, 8'h48, 8'h70,
		8'h48, 8'h60, 8'h90, 8'he0};
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;
	int s, t, n;

	sar_adc_control_regs uut (.clk(clk), .rstn(rstn), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_op(bus_bit_op),
		.bus_bit_sel(bus_bit_sel), .bus_wdata(bus_wdata),
		.bus_wide(bus_wide), .bus_rdata(bus_rdata),
		.bus_rvalid(bus_rvalid), .comp_decision(comp_decision),
		.comparator_on(comparator_on), .sample_hold(sample_hold),
		.channel_sel(channel_sel), .dac_code(dac_code),
		.conversion_done_irq(conversion_done_irq));

	afe_model partner (.clk(clk), .rstn(rstn), .comparator_on(comparator_on),
		.sample_hold(sample_hold), .channel_sel(channel_sel),
		.dac_code(dac_code), .levels(LV), .comp_decision(comp_decision));

	// ********************************
	// Clock, timeout and report
	// ********************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("Comparisons %0d, errors %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// The whole run needs about 4600 cycles; a hang stops well past that.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	// ********************************
	// Bus tasks
	// ********************************
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic bo, input logic [2:0] bs);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_bit_op <= bo;
		bus_bit_sel <= bs;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rdc(input string what, input logic [15:0] a,
		input logic w, input logic [15:0] exp);
		@(posedge clk);
		bus_addr <= a;
		bus_wide <= w;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		chk("rvalid", 16'h0001, {15'h0000, bus_rvalid});
		chk(what, exp, bus_rdata);
	endtask

	task automatic wait_irq(input int lim, output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (conversion_done_irq !== 1'b1 && k < lim);
	endtask

	// Counts sampling cycles and cycles from the first sampling cycle up to the done pulse.
	task automatic measure(output int sl, output int tl);
		int g;
		g = 0;
		do begin
			@(negedge clk);
			g++;
		end while (sample_hold !== 1'b1 && g < 100);
		sl = 1;
		tl = 0;
		do begin
			@(negedge clk);
			tl++;
			if (sample_hold === 1'b1 && sl == tl) begin
				sl++;
			end
		end while (conversion_done_irq !== 1'b1 && tl < 1000);
	endtask

	// ********************************
	// Tests
	// ********************************
	initial begin
		rstn = 1'b0;
		bus_addr = 16'h0000;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_bit_op = 1'b0;
		bus_bit_sel = 3'h0;
		bus_wdata = 8'h00;
		bus_wide = 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rdc("mode", adc_ctl_pkg::ADDR_MODE, 1'b0, 16'h0000);
		rdc("chan", adc_ctl_pkg::ADDR_CHAN, 1'b0, 16'h0000);
		chk("comp idle", 16'h0000, {15'h0000, comparator_on});
		wr(adc_ctl_pkg::ADDR_CHAN, 8'h03, 1'b0, 3'h0);
		wr(adc_ctl_pkg::ADDR_CHAN, 8'h00, 1'b1, 3'h0);
		rdc("chan bit", adc_ctl_pkg::ADDR_CHAN, 1'b0, 16'h0002);
		for (int i = 0; i < 8; i++) begin
			lv = LV[i % 4 * 10 +: 10];
			wr(adc_ctl_pkg::ADDR_CHAN, 8'(i % 4), 1'b0, 3'h0);
			md = {2'b00, 3'(i), 3'b001};
			wr(adc_ctl_pkg::ADDR_MODE, md, 1'b0, 3'h0);
			repeat (30) @(negedge clk);
			chk("comp on", 16'h0001, {15'h0000, comparator_on});
			wr(adc_ctl_pkg::ADDR_MODE, 8'h01, 1'b1, 3'h7);
			measure(s, t);
			chk("sample len", {8'h00, sample_tab[i]}, 16'(s));
			chk("total len", {8'h00, total_tab[i]}, 16'(t));
			wait_irq(1000, n);
			chk("repeat len", {8'h00, total_tab[i]}, 16'(n));
			chk("channel", 16'(i % 4), {14'h0000, channel_sel});
			rdc("full", adc_ctl_pkg::ADDR_RES_LO, 1'b1, {6'h00, lv});
			rdc("high", adc_ctl_pkg::ADDR_RES_HI, 1'b0, {14'h0000, lv[9:8]});
			rdc("low", adc_ctl_pkg::ADDR_RES_LO, 1'b0, {8'h00, lv[7:0]});
			rdc("short", adc_ctl_pkg::ADDR_RES_SHORT, 1'b0, {8'h00, lv[9:2]});
			rdc("mode run", adc_ctl_pkg::ADDR_MODE, 1'b0, {8'h00, md | 8'h80});
			wr(adc_ctl_pkg::ADDR_MODE, 8'h00, 1'b1, 3'h7);
			wait_irq(300, n);
			chk("stopped", 16'h0000, {15'h0000, conversion_done_irq});
			chk("hold low", 16'h0000, {15'h0000, sample_hold});
		end
		wr(adc_ctl_pkg::ADDR_MODE, 8'h00, 1'b0, 3'h0);
		repeat (3) @(negedge clk);
		chk("full stop", 16'h0000, {15'h0000, comparator_on});
		wr(adc_ctl_pkg::ADDR_MODE, 8'h80, 1'b0, 3'h0);
		wait_irq(100, n);
		chk("cold start", 16'h0001, {15'h0000, conversion_done_irq});
		chk("comp run", 16'h0001, {15'h0000, comparator_on});
		wait_irq(1000, n);
		rdc("second", adc_ctl_pkg::ADDR_RES_LO, 1'b1, {6'h00, LV[39:30]});
		repeat (15) @(posedge clk);
		wr(adc_ctl_pkg::ADDR_CHAN, 8'h01, 1'b0, 3'h0);
		wait_irq(1000, n);
		chk("restart", 16'h0026, 16'(n));
		rdc("new chan", adc_ctl_pkg::ADDR_RES_LO, 1'b1, {6'h00, LV[19:10]});
		wr(adc_ctl_pkg::ADDR_MODE, 8'h00, 1'b0, 3'h0);
		wr(adc_ctl_pkg::ADDR_RES_LO, 8'h55, 1'b0, 3'h0);
		rdc("ro full", adc_ctl_pkg::ADDR_RES_LO, 1'b1, {6'h00, LV[19:10]});
		rdc("unmapped", 16'hff20, 1'b0, 16'h0000);
		report_and_stop();
	end
endmodule // sar_adc_control_regs_tb
